// File: design/tpg_chan.sv
// one channel of the test pattern generator
// assumes i_word_stb marks each output word of the serializer
`timescale 1ns/10ps
module tpg_chan
    import tpg_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // word timing and layout
    input wire logic i_word_stb,
    input wire logic i_wide,
    // settings
    input wire logic i_enable,
    input wire tpg_sel_t i_select,
    input wire logic [3:0] i_step,
    input wire logic [23:0] i_pat0,
    input wire logic [23:0] i_pat1,
    // conversion result
    input wire logic [15:0] i_conv,
    // output word and state
    output logic [23:0] o_word,
    output logic o_phase
);

    // ************************************************
    // next values
    // ************************************************
    logic [23:0] ramp_reg; // running ramp value
    wire [23:0] ramp_next = ramp_reg + {20'h00000, i_step} + 24'h000001;
    wire is_ramp = i_enable & (i_select == TPG_SEL_RAMP);
    wire is_alt = i_enable & (i_select == TPG_SEL_ALT);
    // alternate picks pattern one on odd words
    wire [23:0] alt_word = o_phase ? i_pat1 : i_pat0;
    // select 0 and 1 both land on pattern zero
    wire [23:0] pat_word = is_ramp ? ramp_reg : (is_alt ? alt_word : i_pat0);
    // conversion result sits at the top of the slot
    wire [23:0] conv_word = i_wide ? {i_conv, 8'h00} : {4'h0, i_conv, 4'h0};
    wire [23:0] word_next = i_enable ? tpg_slot(i_wide, pat_word) : conv_word;

    // ************************************************
    // word register; all settings sampled at one edge
    // ************************************************
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_word <= TPG_RAMP_RST;
            ramp_reg <= TPG_RAMP_RST;
            o_phase <= 1'b0;
        end else if (i_word_stb) begin
            o_word <= word_next;
            // ramp restarts from zero when left
            ramp_reg <= is_ramp ? ramp_next : TPG_RAMP_RST;
            o_phase <= is_alt & ~o_phase;
        end
    end

endmodule : tpg_chan

// File: design/tpg_pkg.sv
// constants, types and helpers for the dual channel test pattern generator
// assumes a 125 MHz core clock and registers reached over an apb slave
//
// How it works
// - pattern zero low sixteen bits from own register
// - pattern zero top byte from next register
// - pattern one low byte from mixed register
// - pattern one upper sixteen bits dedicated
// - ramp advances by step field plus one
// - select 0 or 1 gives fixed pattern zero
// - select 2 gives incrementing ramp
// - select 3 alternates patterns zero and one
// - enable set replaces data with pattern
// - enable clear sends real conversion result
// - channel a has its own control register
// - word carries 20 or 24 bits per lanes
package tpg_pkg;

    // ************************************************
    // register indices; byte address is four times these
    // ************************************************
    localparam logic [7:0] TPG_IDX_LANES = 8'h12; // lane layout
    localparam logic [7:0] TPG_IDX_A_CTL = 8'h13; // channel a control
    localparam logic [7:0] TPG_IDX_A_P0L = 8'h14; // chan_a_pattern0_low
    localparam logic [7:0] TPG_IDX_A_MIX = 8'h15; // chan_a_pattern_mixed
    localparam logic [7:0] TPG_IDX_A_P1H = 8'h16; // chan_a_pattern1_high
    localparam logic [7:0] TPG_IDX_B_CTL = 8'h18; // chan_b_pattern_control
    localparam logic [7:0] TPG_IDX_B_P0L = 8'h19; // chan_b_pattern0_low
    localparam logic [7:0] TPG_IDX_B_MIX = 8'h1A; // chan_b_pattern_mixed
    localparam logic [7:0] TPG_IDX_B_P1H = 8'h1B; // channel b pattern one high
    localparam logic [7:0] TPG_IDX_STAT = 8'h1E; // generator status

    // ************************************************
    // field positions and reset values
    // ************************************************
    localparam int TPG_EN_BIT = 1; // pattern enable
    localparam int TPG_SEL_LO = 2; // pattern select low bit
    localparam int TPG_STEP_LO = 4; // ramp step low bit
    localparam int TPG_WIDE_BIT = 1; // lanes bit picking 24 bit words
    localparam logic [2:0] TPG_LANES_RST = 3'h2; // two lanes, 24 bits
    localparam logic [15:0] TPG_REG_RST = 16'h0000; // every other register
    localparam logic [23:0] TPG_RAMP_RST = 24'h000000; // ramp start value

    // pattern select encodings
    typedef enum logic [1:0] {
        TPG_SEL_FIX0 = 2'b00,
        TPG_SEL_FIX0_ALSO = 2'b01,
        TPG_SEL_RAMP = 2'b10,
        TPG_SEL_ALT = 2'b11
    } tpg_sel_t;

    // byte address of a register index
    function automatic logic [11:0] tpg_byte_addr(input logic [7:0] idx);
        tpg_byte_addr = {2'b00, idx, 2'b00};
    endfunction : tpg_byte_addr

    // place a 24 bit value into the data slot of the word
    function automatic logic [23:0] tpg_slot(input logic wide, input logic [23:0] val);
        tpg_slot = wide ? val : {4'h0, val[19:0]};
    endfunction : tpg_slot

endpackage : tpg_pkg

// File: design/tpg_top.sv
// top of the dual channel test pattern generator
// holds the apb register file and both channel generators
// assumes apb signals and word strobe synchronous to i_core_clk
//
// Chosen here: the APB slave port.
`timescale 1ns/10ps
module tpg_top
    import tpg_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    // sample stream in
    input wire logic i_word_stb,
    input wire logic [15:0] i_conv_a,
    input wire logic [15:0] i_conv_b,
    // sample stream out
    output logic [23:0] o_word_a,
    output logic [23:0] o_word_b,
    output logic o_word_vld,
    output logic o_word_wide
);

    // ************************************************
    // register storage
    // ************************************************
    // lane layout field
    logic [2:0] lanes_reg;
    // channel a control fields
    logic [7:1] a_ctl_reg;
    // channel a pattern words
    logic [15:0] a_p0l_reg;
    logic [15:0] a_mix_reg;
    logic [15:0] a_p1h_reg;
    // channel b control fields
    logic [7:1] b_ctl_reg;
    // channel b pattern words
    logic [15:0] b_p0l_reg;
    logic [15:0] b_mix_reg;
    logic [15:0] b_p1h_reg;

    // ************************************************
    // apb handshake state
    // ************************************************
    // one wait state so read data comes from a flop
    logic pready_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;

    // ************************************************
    // address decode
    // ************************************************
    wire hit_lanes = (i_paddr == tpg_byte_addr(TPG_IDX_LANES));
    wire hit_a_ctl = (i_paddr == tpg_byte_addr(TPG_IDX_A_CTL));
    wire hit_a_p0l = (i_paddr == tpg_byte_addr(TPG_IDX_A_P0L));
    wire hit_a_mix = (i_paddr == tpg_byte_addr(TPG_IDX_A_MIX));
    wire hit_a_p1h = (i_paddr == tpg_byte_addr(TPG_IDX_A_P1H));
    wire hit_b_ctl = (i_paddr == tpg_byte_addr(TPG_IDX_B_CTL));
    wire hit_b_p0l = (i_paddr == tpg_byte_addr(TPG_IDX_B_P0L));
    wire hit_b_mix = (i_paddr == tpg_byte_addr(TPG_IDX_B_MIX));
    wire hit_b_p1h = (i_paddr == tpg_byte_addr(TPG_IDX_B_P1H));
    wire hit_stat = (i_paddr == tpg_byte_addr(TPG_IDX_STAT));
    // any mapped register
    wire hit_any = hit_lanes | hit_a_ctl | hit_a_p0l | hit_a_mix | hit_a_p1h
                 | hit_b_ctl | hit_b_p0l | hit_b_mix | hit_b_p1h | hit_stat;

    // ************************************************
    // transfer phases
    // ************************************************
    // first access cycle: data gets prepared
    wire acc_first = i_psel & i_penable & ~pready_reg;
    // completing edge: the master sees pready high here
    wire acc_done = i_psel & i_penable & pready_reg;
    // a write lands only on the completing edge
    wire wr_en = acc_done & i_pwrite;
    // status is read only, writes to it are dropped
    wire wr_lanes = wr_en & hit_lanes;
    wire wr_a_ctl = wr_en & hit_a_ctl;
    wire wr_a_p0l = wr_en & hit_a_p0l;
    wire wr_a_mix = wr_en & hit_a_mix;
    wire wr_a_p1h = wr_en & hit_a_p1h;
    wire wr_b_ctl = wr_en & hit_b_ctl;
    wire wr_b_p0l = wr_en & hit_b_p0l;
    wire wr_b_mix = wr_en & hit_b_mix;
    wire wr_b_p1h = wr_en & hit_b_p1h;

    // ************************************************
    // channel state seen by software
    // ************************************************
    // alternate phase of each channel
    logic a_phase;
    logic b_phase;

    // ************************************************
    // read mux
    // ************************************************
    // reserved bits read back as zero
    wire [31:0] rd_lanes = {29'h0, lanes_reg};
    wire [31:0] rd_a_ctl = {24'h0, a_ctl_reg, 1'b0};
    wire [31:0] rd_b_ctl = {24'h0, b_ctl_reg, 1'b0};
    wire [31:0] rd_a_p0l = {16'h0, a_p0l_reg};
    wire [31:0] rd_a_mix = {16'h0, a_mix_reg};
    wire [31:0] rd_a_p1h = {16'h0, a_p1h_reg};
    wire [31:0] rd_b_p0l = {16'h0, b_p0l_reg};
    wire [31:0] rd_b_mix = {16'h0, b_mix_reg};
    wire [31:0] rd_b_p1h = {16'h0, b_p1h_reg};
    // status shows the live alternate phases
    wire [31:0] rd_stat = {30'h0, b_phase, a_phase};
    // one hot select; unmapped reads return zero
    wire [31:0] rd_data = ({32{hit_lanes}} & rd_lanes)
                        | ({32{hit_a_ctl}} & rd_a_ctl)
                        | ({32{hit_a_p0l}} & rd_a_p0l)
                        | ({32{hit_a_mix}} & rd_a_mix)
                        | ({32{hit_a_p1h}} & rd_a_p1h)
                        | ({32{hit_b_ctl}} & rd_b_ctl)
                        | ({32{hit_b_p0l}} & rd_b_p0l)
                        | ({32{hit_b_mix}} & rd_b_mix)
                        | ({32{hit_b_p1h}} & rd_b_p1h)
                        | ({32{hit_stat}} & rd_stat);

    // ************************************************
    // apb answer
    // ************************************************
    // pready rises one cycle into the access phase
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end else if (acc_first) begin
            pready_reg <= 1'b1;
            // read data held stable through the completing edge
            prdata_reg <= i_pwrite ? 32'h00000000 : rd_data;
            // unmapped address or write to status is an error
            pslverr_reg <= ~hit_any | (i_pwrite & hit_stat);
        end else begin
            // drops right after the completing edge
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    // ************************************************
    // lane layout register
    // ************************************************
    // only the word width bit matters to this block
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lanes_reg <= TPG_LANES_RST;
        end else if (wr_lanes) begin
            lanes_reg <= i_pwdata[2:0];
        end
    end

    // ************************************************
    // channel a control
    // ************************************************
    // bit 0 and upper byte are reserved and not stored
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            a_ctl_reg <= TPG_REG_RST[7:1];
        end else if (wr_a_ctl) begin
            a_ctl_reg <= i_pwdata[7:1];
        end
    end

    // ************************************************
    // channel a patterns
    // ************************************************
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            a_p0l_reg <= TPG_REG_RST;
            a_mix_reg <= TPG_REG_RST;
            a_p1h_reg <= TPG_REG_RST;
        end else begin
            if (wr_a_p0l) begin
                a_p0l_reg <= i_pwdata[15:0];
            end
            if (wr_a_mix) begin
                a_mix_reg <= i_pwdata[15:0];
            end
            if (wr_a_p1h) begin
                a_p1h_reg <= i_pwdata[15:0];
            end
        end
    end

    // ************************************************
    // channel b control
    // ************************************************
    // reserved bits are never stored, so they read zero
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            b_ctl_reg <= TPG_REG_RST[7:1];
        end else if (wr_b_ctl) begin
            b_ctl_reg <= i_pwdata[7:1];
        end
    end

    // ************************************************
    // channel b patterns
    // ************************************************
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            b_p0l_reg <= TPG_REG_RST;
            b_mix_reg <= TPG_REG_RST;
            b_p1h_reg <= TPG_REG_RST;
        end else begin
            if (wr_b_p0l) begin
                b_p0l_reg <= i_pwdata[15:0];
            end
            if (wr_b_mix) begin
                b_mix_reg <= i_pwdata[15:0];
            end
            if (wr_b_p1h) begin
                b_p1h_reg <= i_pwdata[15:0];
            end
        end
    end

    // ************************************************
    // pattern assembly
    // ************************************************
    // pattern zero: top byte from the mixed register
    wire [23:0] a_pat0 = {a_mix_reg[7:0], a_p0l_reg};
    wire [23:0] b_pat0 = {b_mix_reg[7:0], b_p0l_reg};
    // pattern one: low byte from the mixed register
    wire [23:0] a_pat1 = {a_p1h_reg, a_mix_reg[15:8]};
    wire [23:0] b_pat1 = {b_p1h_reg, b_mix_reg[15:8]};

    // ************************************************
    // control field split
    // ************************************************
    // enable, select and step for each channel
    wire a_enable = a_ctl_reg[TPG_EN_BIT];
    wire b_enable = b_ctl_reg[TPG_EN_BIT];
    wire [1:0] a_sel_bits = a_ctl_reg[TPG_SEL_LO +: 2];
    wire [1:0] b_sel_bits = b_ctl_reg[TPG_SEL_LO +: 2];
    wire tpg_sel_t a_select = tpg_sel_t'(a_sel_bits);
    wire tpg_sel_t b_select = tpg_sel_t'(b_sel_bits);
    wire [3:0] a_step = a_ctl_reg[TPG_STEP_LO +: 4];
    wire [3:0] b_step = b_ctl_reg[TPG_STEP_LO +: 4];
    // 20 bit words when the width bit is clear
    wire word_wide = lanes_reg[TPG_WIDE_BIT];

    // ************************************************
    // channel generators
    // ************************************************
    // a write mid word only shows at the next strobe
    tpg_chan u_chan_a (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_word_stb(i_word_stb),
        .i_wide(word_wide),
        .i_enable(a_enable),
        .i_select(a_select),
        .i_step(a_step),
        .i_pat0(a_pat0),
        .i_pat1(a_pat1),
        .i_conv(i_conv_a),
        .o_word(o_word_a),
        .o_phase(a_phase)
    );

    // channel b mirrors channel a with its own settings
    tpg_chan u_chan_b (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_word_stb(i_word_stb),
        .i_wide(word_wide),
        .i_enable(b_enable),
        .i_select(b_select),
        .i_step(b_step),
        .i_pat0(b_pat0),
        .i_pat1(b_pat1),
        .i_conv(i_conv_b),
        .o_word(o_word_b),
        .o_phase(b_phase)
    );

    // ************************************************
    // stream flags
    // ************************************************
    // valid pulses with the word update; width follows it
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_word_vld <= 1'b0;
            o_word_wide <= TPG_LANES_RST[TPG_WIDE_BIT];
        end else begin
            o_word_vld <= i_word_stb;
            if (i_word_stb) begin
                o_word_wide <= word_wide;
            end
        end
    end

    // ************************************************
    // output drive
    // ************************************************
    assign o_pready = pready_reg;
    assign o_prdata = prdata_reg;
    assign o_pslverr = pslverr_reg;

endmodule : tpg_top

// File: testbench/tpg_src.sv
// word strobe and conversion source standing in for the sampling front end
// one strobe every gap+1 cycles while running; same clock as the block
`timescale 1ns/10ps
module tpg_src (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // control from the bench
    input wire logic i_run,
    input wire logic [3:0] i_gap,
    // stream toward the block
    output logic o_word_stb,
    output logic [15:0] o_conv_a,
    output logic [15:0] o_conv_b,
    // last results handed over, for the bench's expectations
    output logic [15:0] o_sent_a,
    output logic [15:0] o_sent_b
);
    logic [3:0] wait_reg; // cycles left before next strobe
    logic [15:0] val_reg; // result presented at next strobe
    logic fire; // strobe due next cycle
    // results are valid only in the strobe cycle; inverted otherwise so stale data shows up
    assign o_conv_a = o_word_stb ? val_reg : ~val_reg;
    assign o_conv_b = o_word_stb ? ~val_reg : val_reg;
    assign fire = i_run && wait_reg == 4'h0;
    // strobe pacing and result sequence
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_word_stb <= 1'h0;
            wait_reg <= 4'h0;
            val_reg <= 16'h1357;
            o_sent_a <= 16'h0;
            o_sent_b <= 16'h0;
        end else begin
            o_word_stb <= fire;
            wait_reg <= (wait_reg == 4'h0) ? (fire ? i_gap : 4'h0) : wait_reg - 4'h1;
            if (o_word_stb) begin
                val_reg <= val_reg + 16'h2469;
                o_sent_a <= o_conv_a;
                o_sent_b <= o_conv_b;
            end
        end
    end
endmodule : tpg_src

// File: testbench/tpg_top_bench.sv
// self-checking bench for the dual channel test pattern generator
// assumes tpg_pkg, tpg_top, tpg_src and the bound checker are compiled first
`timescale 1ns/10ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tpg_top_bench
    import tpg_pkg::*;
;
    logic i_core_clk, i_rst_n, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata;
    logic i_word_stb, o_word_vld, o_word_wide, run;
    logic [15:0] i_conv_a, i_conv_b, sent_a, sent_b;
    logic [23:0] o_word_a, o_word_b;
    logic [3:0] gap;
    int errors, comparisons;
    // ************************************************
    // clock, design and stream source
    // ************************************************
    initial begin
        i_core_clk = 1'h0;
        forever #4 i_core_clk = ~i_core_clk;
    end
    tpg_top dut_u (.i_core_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready,
        .o_prdata, .o_pslverr, .i_word_stb, .i_conv_a, .i_conv_b, .o_word_a, .o_word_b, .o_word_vld, .o_word_wide);
    tpg_src src_u (.i_core_clk, .i_rst_n, .i_run(run), .i_gap(gap), .o_word_stb(i_word_stb),
        .o_conv_a(i_conv_a), .o_conv_b(i_conv_b), .o_sent_a(sent_a), .o_sent_b(sent_b));
    // ************************************************
    // shared tasks
    // ************************************************
    task conclude;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    // one apb transfer; request held until ready is seen at an edge
    task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge i_core_clk);
        i_psel <= 1'h1;
        i_pwrite <= wr;
        i_paddr <= {2'h0, idx, 2'h0};
        i_pwdata <= wd;
        @(posedge i_core_clk);
        i_penable <= 1'h1;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (o_pready !== 1'h1 && n < 16);
        if (o_pready !== 1'h1) begin
            errors++;
            conclude();
        end
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'h0;
        i_penable <= 1'h0;
    endtask : apb
    task reg_wr(input logic [7:0] idx, input logic [15:0] d);
        logic [31:0] r;
        logic e;
        apb(1'h1, idx, {16'h0, d}, r, e);
        `CHK(e, 1'h0)
    endtask : reg_wr
    task reg_rd(input logic [7:0] idx, input logic [31:0] exp, input logic experr);
        logic [31:0] r;
        logic e;
        apb(1'h0, idx, 32'h0, r, e);
        `CHK(r, exp)
        `CHK(e, experr)
    endtask : reg_rd
    // control word; reserved bits always left zero
    function automatic logic [15:0] ctl(input logic [3:0] step, input logic [1:0] sel, input logic en);
        ctl = {8'h0, step, sel, en, 1'h0};
    endfunction : ctl
    // stop or restart the stream; stopping lets the last word drain first
    task stream(input logic on, input logic [3:0] g);
        @(posedge i_core_clk);
        run <= on;
        gap <= g;
        if (!on) repeat (4) @(posedge i_core_clk);
    endtask : stream
    // wait for the next word and return it; sent_a and sent_b then hold the results behind it
    task word(output logic [23:0] a, output logic [23:0] b);
        int n;
        n = 0;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (o_word_vld !== 1'h1 && n < 64);
        if (o_word_vld !== 1'h1) begin
            errors++;
            conclude();
        end
        a = o_word_a;
        b = o_word_b;
    endtask : word
    // ************************************************
    // scenarios
    // ************************************************
    task automatic t_reset;
        logic [7:0] idx [8] = '{TPG_IDX_A_CTL, TPG_IDX_A_P0L, TPG_IDX_A_MIX, TPG_IDX_A_P1H,
            TPG_IDX_B_CTL, TPG_IDX_B_P0L, TPG_IDX_B_MIX, TPG_IDX_B_P1H};
        logic [31:0] r;
        logic e;
        logic [23:0] a, b;
        reg_rd(TPG_IDX_LANES, 32'h2, 1'h0);
        foreach (idx[i]) reg_rd(idx[i], 32'h0, 1'h0);
        reg_rd(TPG_IDX_STAT, 32'h0, 1'h0);
        reg_rd(8'h17, 32'h0, 1'h1);
        apb(1'h1, TPG_IDX_STAT, 32'h3, r, e);
        `CHK(e, 1'h1)
        stream(1'h1, 4'h2);
        word(a, b);
        `CHK(a, {sent_a, 8'h00})
        `CHK(b, {sent_b, 8'h00})
        `CHK(o_word_wide, 1'h1)
        stream(1'h0, 4'h2);
        $display("test reset done");
    endtask : t_reset
    task automatic t_regs;
        logic [7:0] idx [6] = '{TPG_IDX_A_P0L, TPG_IDX_A_MIX, TPG_IDX_A_P1H, TPG_IDX_B_P0L, TPG_IDX_B_MIX, TPG_IDX_B_P1H};
        logic [15:0] d [6] = '{16'h1234, 16'h9A56, 16'hBCDE, 16'hF00D, 16'h3C7E, 16'h4182};
        foreach (idx[i]) reg_wr(idx[i], d[i]);
        foreach (idx[i]) reg_rd(idx[i], {16'h0, d[i]}, 1'h0);
        $display("test regs done");
    endtask : t_regs
    task t_fixed;
        logic [23:0] a, b;
        for (int s = 0; s < 2; s++) begin
            reg_wr(TPG_IDX_A_CTL, ctl(4'h5, s[1:0], 1'h1));
            reg_wr(TPG_IDX_B_CTL, ctl(4'h0, s[1:0], 1'h1));
            reg_rd(TPG_IDX_A_CTL, {16'h0, ctl(4'h5, s[1:0], 1'h1)}, 1'h0);
            stream(1'h1, 4'h2);
            repeat (2) begin
                word(a, b);
                `CHK(a, 24'h561234)
                `CHK(b, 24'h7EF00D)
            end
            stream(1'h0, 4'h2);
        end
        $display("test fixed done");
    endtask : t_fixed
    task t_alt;
        logic [23:0] a, b;
        reg_wr(TPG_IDX_A_CTL, ctl(4'h0, 2'h3, 1'h1));
        reg_wr(TPG_IDX_B_CTL, ctl(4'h0, 2'h3, 1'h1));
        stream(1'h1, 4'h0);
        for (int k = 0; k < 4; k++) begin
            word(a, b);
            `CHK(a, k[0] ? 24'hBCDE9A : 24'h561234)
            `CHK(b, k[0] ? 24'h41823C : 24'h7EF00D)
        end
        stream(1'h0, 4'h0);
        $display("test alternate done");
    endtask : t_alt
    task t_ramp;
        logic [23:0] a, b;
        reg_wr(TPG_IDX_A_CTL, ctl(4'hF, 2'h2, 1'h1));
        reg_wr(TPG_IDX_B_CTL, ctl(4'h0, 2'h2, 1'h1));
        stream(1'h1, 4'h0);
        for (int k = 0; k < 6; k++) begin
            word(a, b);
            `CHK(a, 24'(k * 16))
            `CHK(b, 24'(k))
        end
        stream(1'h0, 4'h0);
        $display("test ramp done");
    endtask : t_ramp
    task t_narrow;
        logic [23:0] a, b;
        reg_wr(TPG_IDX_LANES, 16'h0000);
        reg_wr(TPG_IDX_A_CTL, ctl(4'h0, 2'h0, 1'h0));
        reg_wr(TPG_IDX_B_CTL, ctl(4'h0, 2'h1, 1'h1));
        stream(1'h1, 4'h1);
        word(a, b);
        `CHK(a, {4'h0, sent_a, 4'h0})
        `CHK(b, 24'h0EF00D)
        `CHK(o_word_wide, 1'h0)
        stream(1'h0, 4'h1);
        $display("test narrow done");
    endtask : t_narrow
    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        i_rst_n = 1'h0;
        i_psel = 1'h0;
        i_penable = 1'h0;
        i_pwrite = 1'h0;
        i_paddr = 12'h0;
        i_pwdata = 32'h0;
        run = 1'h0;
        gap = 4'h0;
        errors = 0;
        comparisons = 0;
        repeat (2) @(posedge i_core_clk);
        i_rst_n <= 1'h1;
        t_reset();
        t_regs();
        t_fixed();
        t_alt();
        t_ramp();
        t_narrow();
        conclude();
    end
endmodule : tpg_top_bench

// File: testbench/tpg_top_props.sv
// checker for the test pattern generator top ports
// bound to tpg_top below; sees only the top module's ports
`timescale 1ns/10ps
module tpg_props (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // apb slave side
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic o_pready,
    input wire logic [31:0] o_prdata,
    input wire logic o_pslverr,
    // sample stream
    input wire logic i_word_stb,
    input wire logic [23:0] o_word_a,
    input wire logic [23:0] o_word_b,
    input wire logic o_word_vld,
    input wire logic o_word_wide
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);
    // apb steps: a setup cycle, then exactly one wait before ready
    sequence s_setup;
        i_psel && !i_penable;
    endsequence
    sequence s_one_wait;
        !o_pready ##1 o_pready;
    endsequence
    a_apb_one_wait: assert property (s_setup |=> s_one_wait)
        else $error("apb ready not after one wait state");
    a_ready_single: assert property (o_pready |=> !o_pready)
        else $error("apb ready held too long");
    a_err_with_ready: assert property (o_pslverr |-> o_pready)
        else $error("apb error without ready");
    a_write_data_zero: assert property (o_pready && i_pwrite |-> o_prdata == 32'h0)
        else $error("read data not zero on write");
    a_err_data_zero: assert property (o_pslverr |-> o_prdata == 32'h0)
        else $error("read data not zero on refused access");
    a_vld_after_stb: assert property (i_word_stb |=> o_word_vld)
        else $error("word valid missing after strobe");
    a_no_stray_vld: assert property (!i_word_stb |=> !o_word_vld)
        else $error("word valid without strobe");
    // words may only move at a word boundary, never in between
    a_words_hold: assert property (!i_word_stb |=> $stable(o_word_a) && $stable(o_word_b))
        else $error("output word changed between strobes");
    a_narrow_slot: assert property (o_word_vld && !o_word_wide |-> o_word_a[23:20] == 4'h0 && o_word_b[23:20] == 4'h0)
        else $error("narrow word has top bits set");
endmodule : tpg_props

bind tpg_top tpg_props chk_u (.i_core_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .o_pready, .o_prdata,
    .o_pslverr, .i_word_stb, .o_word_a, .o_word_b, .o_word_vld, .o_word_wide);
